// >>> core/plbm_defines.vh
`ifndef PLBM_DEFINES_VH
`define PLBM_DEFINES_VH
// ==========================================
// bus and shifter geometry
`define PLBM_BUS_W       8
`define PLBM_SHIFT_W     32
`define PLBM_NUM_SHIFT   8
`define PLBM_BEATS_SINGLE 8'h01
`define PLBM_BEATS_MULTI  8'h20
// ==========================================
// strobe timing: half period in module clocks
`define PLBM_HALF_DIV    8'h02
// ==========================================
// function select encodings
`define PLBM_FN_WR1      2'h0
`define PLBM_FN_RD1      2'h1
`define PLBM_FN_WRM      2'h2
`define PLBM_FN_RDM      2'h3
`endif

// >>> core/plbm_lcd_master.v
// Contract
// [R1] 8-bit data bus, chip select, strobes, register select
// [R2] select and strobes are active low
// [R3] write data held across write strobe rise
// [R4] read data sampled at read strobe rise
// [R5] idle strobe held high during other direction
// [R6] register select low command, high data
// [R7] transaction starts with one command write beat
// [R8] dummy read beat tolerated before data
// [R9] single beat uses one shifter, one shift
// [R10] eight 32-bit shifters give 32 beats
// [R11] one function at a time, reconfigure between
// [R12] multibeat write fill loads all eight buffers
// [R13] buffer write clears flag, enabling timer
// [R14] load empties buffers, sets flag, requests refill
// [R15] timer shift clocks drive the write strobe
// [R16] compare after 32 shifts, re-enable on data
// [R17] no refill means timer stays idle
// [R18] leftover bytes go as single beats
// [R19] read timer starts right after configuration
// [R20] compare then store shifters, flag, request
// [R21] draining buffers clears flag, restarts reads
// [R22] last read burst not re-armed by drain; code re-arms reads on every drain of the last buffer
// [R23] low byte divides clock, high counts edges
// [R24] transmit low bits out, receive into high
// [R25] software drives select around the transfer
`timescale 1ns/1ps
`default_nettype none
`include "plbm_defines.vh"
module plbm_lcd_master #(
  parameter BUS_W = `PLBM_BUS_W,
  parameter NSH   = `PLBM_NUM_SHIFT,
  parameter SW    = `PLBM_SHIFT_W
) (
  // clock and reset
  input  wire                clk_in,
  input  wire                rst_n_in,
  // software control
  input  wire [1:0]          func_in,
  input  wire                cfg_go_in,
  input  wire                cs_n_ctl_in,
  input  wire                reg_select_ctl_in,
  // buffer access, one 32-bit word per shifter
  input  wire                buf_wr_in,
  input  wire [2:0]          buf_idx_in,
  input  wire [SW-1:0]       buf_wdata_in,
  input  wire                buf_rd_in,
  output reg  [SW-1:0]       buf_rdata_out,
  output reg                 flag_out,
  output reg                 dma_req_out,
  output reg                 busy_out,
  // lcd bus pins
  output reg                 cs_n_out,
  output reg                 reg_select_n_out,
  output reg                 wr_n_out,
  output reg                 rd_n_out,
  input  wire [BUS_W-1:0]    bus_data_lines_in,
  output reg  [BUS_W-1:0]    bus_data_lines_out,          // see [R1]
  output reg                 bus_data_oe_out
);
  localparam CH = NSH*SW;
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_GAP  = 2'h2;

  // ==========================================
  // pin synchroniser
  reg [BUS_W-1:0] din_s1_ff, din_s2_ff;
  always @(posedge clk_in) begin
    din_s1_ff <= bus_data_lines_in;
    din_s2_ff <= din_s1_ff;
  end

  // ==========================================
  // state
  reg [1:0]    st_ff;
  reg [1:0]    fn_ff;
  reg [CH-1:0] buf_ff;
  reg [CH-1:0] sh_ff;
  reg [NSH-1:0] full_ff;
  reg [7:0]    lo_ff;
  reg [7:0]    hi_ff;
  reg          armed_ff;

  function [7:0] beats_of;
    input [1:0] f;
    begin
      beats_of = f[1] ? `PLBM_BEATS_MULTI : `PLBM_BEATS_SINGLE; // see [R9] see [R10]
    end
  endfunction

  wire is_rd   = fn_ff[0];
  wire is_multi = fn_ff[1];
  wire all_full = is_multi ? &full_ff : full_ff[0];
  wire lo_zero = (lo_ff == 8'h01);
  wire last_edge = lo_zero && (hi_ff == 8'h00) && strobe_lo;
  wire strobe_lo = is_rd ? !rd_n_out : !wr_n_out;

  integer i;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff <= ST_IDLE;
      fn_ff <= `PLBM_FN_WR1;
      buf_ff <= {CH{1'b0}};
      sh_ff <= {CH{1'b0}};
      full_ff <= {NSH{1'b0}};
      lo_ff <= 8'h00;
      hi_ff <= 8'h00;
      armed_ff <= 1'b0;
      wr_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      cs_n_out <= 1'b1;
      reg_select_n_out <= 1'b1;
      bus_data_lines_out <= {BUS_W{1'b0}};
      bus_data_oe_out <= 1'b0;
      buf_rdata_out <= {SW{1'b0}};
      flag_out <= 1'b1;
      dma_req_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      cs_n_out <= cs_n_ctl_in;                          // see [R25] see [R2]
      reg_select_n_out <= reg_select_ctl_in;            // see [R6] see [R7]
      if (cfg_go_in && st_ff == ST_IDLE) begin
        fn_ff <= func_in;                               // see [R11]
        full_ff <= {NSH{1'b0}};
        armed_ff <= func_in[0];                         // see [R19]
      end
      // software / dma access to buffers
      if (buf_rd_in && is_rd) begin
        buf_rdata_out <= buf_ff[buf_idx_in*SW +: SW];
        full_ff[buf_idx_in] <= 1'b0;
        if (is_multi ? (buf_idx_in == NSH-1) : 1'b1)
          armed_ff <= 1'b1;                             // see [R21] see [R22]
      end
      case (st_ff)
        ST_IDLE, ST_GAP: begin
          wr_n_out <= 1'b1;                             // see [R5]
          rd_n_out <= 1'b1;
          if (!is_rd && all_full && !busy_out) begin    // see [R13] see [R16] see [R17]
            sh_ff <= buf_ff;                            // see [R14]
            full_ff <= {NSH{1'b0}};
            st_ff <= ST_RUN;
          end else if (is_rd && armed_ff && !(is_multi ? |full_ff : full_ff[0])) begin
            armed_ff <= 1'b0;
            st_ff <= ST_RUN;
          end else begin
            st_ff <= ST_IDLE;
          end
          if (st_ff != ST_RUN) begin
            lo_ff <= `PLBM_HALF_DIV;
            hi_ff <= (beats_of(fn_ff) << 1) - 8'h01;    // see [R23]
          end
          bus_data_oe_out <= !is_rd;
        end
        ST_RUN: begin
          if (lo_zero) begin
            lo_ff <= `PLBM_HALF_DIV;
            hi_ff <= hi_ff - 8'h01;
            if (!strobe_lo) begin
              if (is_rd) rd_n_out <= 1'b0;              // see [R15] see [R19]
              else wr_n_out <= 1'b0;
              if (!is_rd)
                bus_data_lines_out <= sh_ff[BUS_W-1:0]; // see [R24] see [R3]
            end else begin
              wr_n_out <= 1'b1;
              rd_n_out <= 1'b1;
              if (is_rd)
                sh_ff <= {din_s2_ff, sh_ff[CH-1:BUS_W]}; // see [R4] see [R8]
              else
                sh_ff <= {{BUS_W{1'b0}}, sh_ff[CH-1:BUS_W]};
            end
          end else begin
            lo_ff <= lo_ff - 8'h01;
          end
          if (last_edge) begin
            st_ff <= ST_GAP;                            // see [R16]
            if (is_rd) begin
              if (is_multi) buf_ff <= {din_s2_ff, sh_ff[CH-1:BUS_W]};   // see [R20]
              else buf_ff[SW-1:0] <= {din_s2_ff, sh_ff[CH-1:CH-SW+BUS_W]};
              full_ff <= {NSH{1'b1}};
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
      // refill after load, so a write in the load cycle keeps its flag
      if (buf_wr_in && !is_rd) begin
        buf_ff[buf_idx_in*SW +: SW] <= buf_wdata_in;
        full_ff[buf_idx_in] <= 1'b1;                    // see [R12]
      end
      busy_out <= (st_ff == ST_RUN) && !last_edge;
      flag_out <= is_rd ? (is_multi ? &full_ff : full_ff[0])
                        : !(is_multi ? |full_ff : full_ff[0]);   // see [R13] see [R14]
      dma_req_out <= is_multi && (is_rd ? &full_ff : ~|full_ff); // see [R18]
    end
  end
endmodule
`default_nettype wire

// >>> verif/plbm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// bus checks
module plbm_checker #(parameter BUS_W = 8) (
  input wire logic             clk_in, rst_n_in, cs_n_ctl_in, reg_select_ctl_in,
  input wire logic             busy_out, bus_data_oe_out, dma_req_out,
  input wire logic             cs_n_out, reg_select_n_out, wr_n_out, rd_n_out,
  input wire logic [BUS_W-1:0] bus_data_lines_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  one_strobe_a: assert property (wr_n_out || rd_n_out)
    else $error("both strobes low");
  cs_follow_a: assert property (cs_n_out == $past(cs_n_ctl_in))
    else $error("select not copied");
  rs_follow_a: assert property (reg_select_n_out == $past(reg_select_ctl_in))
    else $error("reg select not copied");
  wr_hold_a: assert property ($rose(wr_n_out) |-> $stable(bus_data_lines_out))
    else $error("data moved at strobe rise");
  wr_len_a: assert property ($fell(wr_n_out) |-> !wr_n_out [*2] ##1 wr_n_out)
    else $error("write strobe width");
  rd_len_a: assert property ($fell(rd_n_out) |-> !rd_n_out [*2] ##1 rd_n_out)
    else $error("read strobe width");
  wr_drive_a: assert property (!wr_n_out |-> bus_data_oe_out)
    else $error("no drive in write beat");
  rd_float_a: assert property (!rd_n_out |-> !bus_data_oe_out)
    else $error("drive in read beat");
  strobe_busy_a: assert property ($fell(wr_n_out) or $fell(rd_n_out) |-> busy_out)
    else $error("strobe while idle");
  cover property ($fell(wr_n_out));
  cover property ($fell(rd_n_out));
  cover property ($rose(dma_req_out));
endmodule
bind plbm_lcd_master plbm_checker #(.BUS_W(BUS_W)) plbm_checker_i (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .cs_n_ctl_in(cs_n_ctl_in), .reg_select_ctl_in(reg_select_ctl_in),
  .busy_out(busy_out), .bus_data_oe_out(bus_data_oe_out), .dma_req_out(dma_req_out),
  .cs_n_out(cs_n_out), .reg_select_n_out(reg_select_n_out), .wr_n_out(wr_n_out),
  .rd_n_out(rd_n_out), .bus_data_lines_out(bus_data_lines_out));
`default_nettype wire

// >>> verif/plbm_lcd_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// lcd controller model
module plbm_lcd_model (
  input wire logic       cs_n_in, rs_n_in, wr_n_in, rd_n_in,
  input wire logic [7:0] d_in,
  output var logic [7:0] d_out
);
  logic [7:0] mem [0:63];
  logic [63:0] rsq;
  int cnt = 0;
  logic [7:0] rv = 8'ha0;
  // rv while selected and write strobe high, else inverse
  assign d_out = (!cs_n_in && wr_n_in) ? rv : ~rv;
  always @(posedge wr_n_in) if (!cs_n_in) begin
    mem[cnt[5:0]] <= d_in;
    rsq[cnt[5:0]] <= rs_n_in;
    cnt <= cnt + 1;
  end
  always @(posedge rd_n_in) if (!cs_n_in) rv <= rv + 8'h01;
endmodule
`default_nettype wire

// >>> verif/plbm_lcd_master_tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// bench
module plbm_lcd_master_tb;
  logic clk_in = 0, rst_n_in = 0, cfg_go_in = 0, cs_n_ctl_in = 1, reg_select_ctl_in = 1;
  logic buf_wr_in = 0, buf_rd_in = 0, flag_out, dma_req_out, busy_out, oe;
  logic cs_n_out, reg_select_n_out, wr_n_out, rd_n_out;
  logic [1:0] func_in = 0;
  logic [2:0] buf_idx_in = 0;
  logic [31:0] buf_wdata_in = 0, buf_rdata_out;
  logic [7:0] din, dout;
  int fail_count = 0, checks = 0;
  always #4 clk_in = ~clk_in;
  plbm_lcd_master plbm_lcd_master_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .func_in(func_in), .cfg_go_in(cfg_go_in), .cs_n_ctl_in(cs_n_ctl_in),
    .reg_select_ctl_in(reg_select_ctl_in), .buf_wr_in(buf_wr_in), .buf_idx_in(buf_idx_in),
    .buf_wdata_in(buf_wdata_in), .buf_rd_in(buf_rd_in), .buf_rdata_out(buf_rdata_out),
    .flag_out(flag_out), .dma_req_out(dma_req_out), .busy_out(busy_out),
    .cs_n_out(cs_n_out), .reg_select_n_out(reg_select_n_out), .wr_n_out(wr_n_out),
    .rd_n_out(rd_n_out), .bus_data_lines_in(din), .bus_data_lines_out(dout),
    .bus_data_oe_out(oe));
  plbm_lcd_model plbm_lcd_model_i (.cs_n_in(cs_n_out), .rs_n_in(reg_select_n_out),
    .wr_n_in(wr_n_out), .rd_n_in(rd_n_out), .d_in(dout), .d_out(din));
  task chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("fail_count %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wt(input bit b);
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge clk_in);
      #1;
      if (b ? busy_out === 1 : (busy_out === 0 && flag_out === 1)) break;
    end
    if (i == 600) begin
      fail_count++;
      give_verdict;
    end
  endtask
  task start(input logic [1:0] f, input logic rs);
    @(posedge clk_in) begin func_in <= f; reg_select_ctl_in <= rs; cfg_go_in <= 1; end
    @(posedge clk_in) cfg_go_in <= 0;
  endtask
  task put(input int i, input logic [31:0] w);
    @(posedge clk_in) begin buf_wr_in <= 1; buf_idx_in <= i[2:0]; buf_wdata_in <= w; end
    @(posedge clk_in) buf_wr_in <= 0;
  endtask
  task sc_write;
    int k;
    start(2'h0, 0);
    put(0, 32'h5a);
    wt(1);
    wt(0);
    chk(plbm_lcd_model_i.mem[0], 8'h5a);
    chk(plbm_lcd_model_i.rsq[0], 0);
    chk(plbm_lcd_model_i.cnt, 1);
    start(2'h2, 1);
    for (k = 0; k < 8; k++) put(k, {8'h13, 8'h12, 8'h11, 8'h10} + {4{8'(k * 4)}});
    wt(1);
    wt(0);
    chk(plbm_lcd_model_i.cnt, 33);
    for (k = 0; k < 32; k++) chk(plbm_lcd_model_i.mem[k + 1], 8'h10 + k);
    chk(plbm_lcd_model_i.rsq[32:1], 32'hffffffff);
    chk({dma_req_out, busy_out}, 2'h2);
  endtask
  task sc_read;
    start(2'h1, 1);
    wt(1);
    wt(0);
    @(posedge clk_in) begin buf_rd_in <= 1; buf_idx_in <= 0; end
    @(posedge clk_in) buf_rd_in <= 0;
    #1 chk(buf_rdata_out[31:24], 8'ha0);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1;
    #1 chk({cs_n_out, reg_select_n_out, wr_n_out, rd_n_out, oe, flag_out, dma_req_out},
      7'h7a);
    @(posedge clk_in) cs_n_ctl_in <= 0;
    sc_write;
    sc_read;
    give_verdict;
  end
endmodule
`default_nettype wire
